// ### rtl/srb_defs.svh
// Constants for the small embedded RAM block and its user logic
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH
`define SRB_ROWS 32
`define SRB_DW 18
`define SRB_AW 9
`define SRB_INIT_SEED 18'h2aaaa
`define SRB_NONE 18'h00000
`define SRB_CAPACITY 576
`define SRB_MAX_PORT 18
`define SRB_MAX_TAP 32
`define SRB_OFF_CTRL 8'h00
`define SRB_OFF_WADDR 8'h04
`define SRB_OFF_WDATA 8'h08
`define SRB_OFF_RADDR 8'h0c
`define SRB_OFF_RDATA 8'h10
`define SRB_OFF_SHAPE 8'h14
`define SRB_OFF_STAT 8'h18
`define SRB_C_MODE 2:0
`define SRB_C_WWID 6:4
`define SRB_C_RWID 10:8
`define SRB_C_OREG 12
`define SRB_C_PSEUDO 13
`define SRB_C_RSEL 14
`define SRB_C_OSEL 15
`define SRB_C_BANK 16
`define SRB_C_INCE 17
`define SRB_C_OUTCE 18
`define SRB_C_INCLR 19
`define SRB_C_OUTCLR 20
`define SRB_C_CASC 21
`define SRB_C_BE 23:22
`define SRB_S_W 4:0
`define SRB_S_LEN 13:8
`define SRB_S_TAPS 19:16
`define SRB_CTRL_RST 32'h00060000
`endif

// ### rtl/srb_link_if.sv
// Link between the RAM block and the user logic that drives it
`timescale 1ns/1ps
`include "srb_defs.svh"
interface srb_link_if;
   srb_pkg::srb_mode_t mode;
   srb_pkg::srb_wid_t wr_wid;
   srb_pkg::srb_wid_t rd_wid;
   logic out_reg;
   logic pseudo;
   logic rsel;
   logic osel;
   logic bank;
   logic in_ce;
   logic out_ce;
   logic in_clr;
   logic out_clr;
   logic wren;
   logic rden;
   logic [`SRB_AW-1:0] wr_addr;
   logic [`SRB_AW-1:0] rd_addr;
   logic [`SRB_DW-1:0] wr_data;
   logic [1:0] be;
   logic [4:0] shift_w;
   logic [5:0] tap_len;
   logic [`SRB_DW-1:0] q;
   modport ram (
      input mode, wr_wid, rd_wid, out_reg, pseudo, rsel, osel, bank, in_ce, out_ce,
      input in_clr, out_clr, wren, rden, wr_addr, rd_addr, wr_data, be, shift_w, tap_len,
      output q
   );
   modport user (
      output mode, wr_wid, rd_wid, out_reg, pseudo, rsel, osel, bank, in_ce, out_ce,
      output in_clr, out_clr, wren, rden, wr_addr, rd_addr, wr_data, be, shift_w, tap_len,
      input q
   );
endinterface

// ### rtl/srb_pkg.sv
// Types shared by the RAM block, its link and its user logic
`include "srb_defs.svh"
package srb_pkg;
   typedef enum logic [2:0] {SRB_SDP, SRB_SP, SRB_FIFO, SRB_ROM, SRB_SHIFT, SRB_SPLIT} srb_mode_t;
   typedef enum logic [2:0] {SRB_W1, SRB_W2, SRB_W4, SRB_W8, SRB_W16, SRB_W9, SRB_W18} srb_wid_t;
   typedef struct packed {
      logic [`SRB_ROWS-1:0][`SRB_DW-1:0] mem;
      srb_mode_t mode;
      srb_wid_t wr_wid;
      srb_wid_t rd_wid;
      logic out_reg;
      logic pseudo;
      logic bank;
      logic wren;
      logic rden;
      logic [`SRB_AW-1:0] wr_addr;
      logic [`SRB_AW-1:0] rd_addr;
      logic [`SRB_DW-1:0] wr_data;
      logic [1:0] be;
      logic [4:0] shift_w;
      logic [5:0] tap_len;
      logic [4:0] ptr;
      logic rd_go;
      logic [`SRB_DW-1:0] rd_q;
      logic [`SRB_DW-1:0] q;
   } srb_ram_st_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [`SRB_AW-1:0] waddr;
      logic [`SRB_DW-1:0] wdata;
      logic [`SRB_AW-1:0] raddr;
      logic [4:0] shift_w;
      logic [5:0] tap_len;
      logic bad;
      logic wren;
      logic rden;
      logic [`SRB_DW-1:0] q_cap;
      logic ph_wr;
      logic [7:0] ph_addr;
      logic [31:0] hrdata;
      logic hready;
   } srb_usr_st_t;
endpackage

// ### rtl/srb_ram.sv
// Small embedded RAM block: dual/single port RAM, ROM, FIFO store, shift taps
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "srb_defs.svh"
module srb_ram (
   input wire logic CLK_SYS, // System clock
   input wire logic RST, // Synchronous reset, active high
   input wire logic CE, // Global clock enable
   srb_link_if.ram LNK // Link from user logic
);

   srb_pkg::srb_ram_st_t s_r;
   srb_pkg::srb_ram_st_t s_nxt;

   function automatic logic [4:0] wbits(input srb_pkg::srb_wid_t w);
      case (w)
         srb_pkg::SRB_W1: wbits = 5'h01;
         srb_pkg::SRB_W2: wbits = 5'h02;
         srb_pkg::SRB_W4: wbits = 5'h04;
         srb_pkg::SRB_W8: wbits = 5'h08;
         srb_pkg::SRB_W16: wbits = 5'h10;
         srb_pkg::SRB_W9: wbits = 5'h09;
         default: wbits = 5'h12;
      endcase
   endfunction

   function automatic logic is_par(input srb_pkg::srb_wid_t w);
      is_par = (w == srb_pkg::SRB_W9) || (w == srb_pkg::SRB_W18);
   endfunction

   // Bit position in an 18-bit row; plain shapes skip the parity columns
   function automatic logic [4:0] bitpos(input srb_pkg::srb_wid_t w, input logic [4:0] base,
                                         input logic [4:0] i);
      logic [4:0] k;
      k = base + i;
      if (is_par(w)) begin
         bitpos = k;
      end else begin
         bitpos = (k < 5'h08) ? k : k + 5'h01;
      end
   endfunction

   // Row and base column of a word for a given shape
   function automatic logic [9:0] locate(input srb_pkg::srb_wid_t w, input logic [8:0] a,
                                         input logic split, input logic bank);
      logic [12:0] b;
      logic [4:0] row;
      logic [4:0] base;
      b = 13'(a) * 13'(wbits(w));
      row = b[8:4];
      base = {1'b0, b[3:0]};
      if (w == srb_pkg::SRB_W9) begin
         row = a[5:1];
         base = a[0] ? 5'h09 : 5'h00;
      end else if (w == srb_pkg::SRB_W18) begin
         row = a[4:0];
         base = 5'h00;
      end
      if (split) begin
         row[4] = bank;
      end
      locate = {row, base};
   endfunction

   function automatic logic [`SRB_DW-1:0] mem_rd(input logic [`SRB_ROWS-1:0][`SRB_DW-1:0] m,
         input srb_pkg::srb_wid_t w, input logic [8:0] a, input logic split, input logic bank);
      logic [9:0] loc;
      logic [`SRB_DW-1:0] rv;
      logic [`SRB_DW-1:0] r;
      loc = locate(w, a, split, bank);
      rv = m[loc[9:5]];
      r = `SRB_NONE;
      for (int i = 0; i < `SRB_DW; i++) begin
         if (5'(i) < wbits(w)) begin
            r[i] = rv[bitpos(w, loc[4:0], 5'(i))];
         end
      end
      mem_rd = r;
   endfunction

   function automatic logic [`SRB_ROWS-1:0][`SRB_DW-1:0] mem_wr(
         input logic [`SRB_ROWS-1:0][`SRB_DW-1:0] m, input srb_pkg::srb_wid_t w,
         input logic [8:0] a, input logic [`SRB_DW-1:0] d, input logic [1:0] be,
         input logic split, input logic bank);
      logic [9:0] loc;
      logic wide;
      logic lane;
      logic [`SRB_ROWS-1:0][`SRB_DW-1:0] r;
      loc = locate(w, a, split, bank);
      wide = (w == srb_pkg::SRB_W16) || (w == srb_pkg::SRB_W18);
      r = m;
      for (int i = 0; i < `SRB_DW; i++) begin
         lane = (w == srb_pkg::SRB_W18) ? (i >= 9) : (i >= 8);
         if ((5'(i) < wbits(w)) && (!wide || be[lane])) begin
            r[loc[9:5]][bitpos(w, loc[4:0], 5'(i))] = d[i];
         end
      end
      mem_wr = r;
   endfunction

   function automatic logic [`SRB_ROWS-1:0][`SRB_DW-1:0] init_mem();
      logic [`SRB_ROWS-1:0][`SRB_DW-1:0] r;
      for (int i = 0; i < `SRB_ROWS; i++) begin
         r[i] = `SRB_INIT_SEED ^ 18'(i);
      end
      init_mem = r;
   endfunction

   logic rce;
   logic oce;
   logic sp;
   logic split;
   logic pa;
   logic [`SRB_AW-1:0] ra;
   srb_pkg::srb_wid_t rw;
   logic [`SRB_DW-1:0] raw;
   logic [`SRB_DW-1:0] old;
   logic [`SRB_DW-1:0] mask;

   always_comb begin
      rce = LNK.rsel ? LNK.out_ce : LNK.in_ce;
      oce = LNK.osel ? LNK.out_ce : LNK.in_ce;
      split = (s_r.mode == srb_pkg::SRB_SPLIT);
      sp = (s_r.mode == srb_pkg::SRB_SP) || split;
      pa = (s_r.mode == srb_pkg::SRB_SDP) && s_r.pseudo && !s_r.out_reg;
      ra = sp ? s_r.wr_addr : s_r.rd_addr;
      rw = sp ? s_r.wr_wid : s_r.rd_wid;
      raw = mem_rd(s_r.mem, rw, ra, split, s_r.bank);
      old = s_r.mem[s_r.ptr];
      mask = (18'h00001 << s_r.shift_w) - 18'h00001;
      s_nxt = s_r;
      if (RST) begin
         s_nxt = '0;
         s_nxt.mem = init_mem();
         s_nxt.tap_len = 6'h01;
      end else if (CE) begin
         // Input group: write side and configuration
         if (LNK.in_clr) begin
            s_nxt.wren = 1'b0;
            s_nxt.wr_addr = '0;
            s_nxt.wr_data = '0;
         end else if (LNK.in_ce) begin
            s_nxt.mode = LNK.mode;
            s_nxt.wr_wid = LNK.wr_wid;
            s_nxt.rd_wid = LNK.rd_wid;
            s_nxt.out_reg = LNK.out_reg;
            s_nxt.pseudo = LNK.pseudo;
            s_nxt.bank = LNK.bank;
            s_nxt.wren = LNK.wren;
            s_nxt.wr_addr = LNK.wr_addr;
            s_nxt.wr_data = LNK.wr_data;
            s_nxt.be = LNK.be;
            s_nxt.shift_w = LNK.shift_w;
            s_nxt.tap_len = LNK.tap_len;
         end else begin
            s_nxt.wren = 1'b0;
         end
         // Read address group on its selected enable
         if (LNK.in_clr) begin
            s_nxt.rden = 1'b0;
            s_nxt.rd_addr = '0;
         end else if (rce) begin
            s_nxt.rden = LNK.rden;
            s_nxt.rd_addr = LNK.rd_addr;
         end else begin
            s_nxt.rden = 1'b0;
         end
         // Self-timed write one edge after capture
         if (s_r.wren && (s_r.mode == srb_pkg::SRB_SHIFT)) begin
            s_nxt.mem[s_r.ptr] = (old << s_r.shift_w) | (s_r.wr_data & mask);
            s_nxt.q = old;
            s_nxt.ptr = (6'(s_r.ptr) + 6'h01 >= s_r.tap_len) ? 5'h00 : s_r.ptr + 5'h01;
         end else if (s_r.wren && (s_r.mode != srb_pkg::SRB_ROM)) begin
            s_nxt.mem = mem_wr(s_r.mem, s_r.wr_wid, s_r.wr_addr, s_r.wr_data, s_r.be,
                               split, s_r.bank);
         end
         // Read path; old data on a same-address write, but single port and split skip the read
         s_nxt.rd_go = 1'b0;
         if (pa) begin
            if (rce && LNK.rden) begin
               s_nxt.q = mem_rd(s_r.mem, s_r.rd_wid, LNK.rd_addr, 1'b0, 1'b0);
            end
         end else if (s_r.mode != srb_pkg::SRB_SHIFT) begin
            if (s_r.rden && !(sp && s_r.wren)) begin
               if (s_r.out_reg) begin
                  s_nxt.rd_q = raw;
                  s_nxt.rd_go = 1'b1;
               end else begin
                  s_nxt.q = raw;
               end
            end
            if (s_r.out_reg && s_r.rd_go && oce) begin
               s_nxt.q = s_r.rd_q;
            end
         end
         if (LNK.out_clr) begin
            s_nxt.q = '0;
            s_nxt.rd_q = '0;
            s_nxt.rd_go = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      s_r <= s_nxt;
   end

   assign LNK.q = s_r.q;

endmodule

// ### rtl/srb_user.sv
// User logic end: AHB-Lite registers that drive the RAM block link
`timescale 1ns/1ps
`include "srb_defs.svh"
module srb_user (
   input wire logic CLK_SYS, // System clock
   input wire logic RST, // Synchronous reset, active high
   input wire logic CE, // Global clock enable
   input wire logic HSEL, // AHB slave select
   input wire logic [31:0] HADDR, // AHB address
   input wire logic [1:0] HTRANS, // AHB transfer type
   input wire logic HWRITE, // AHB write
   input wire logic [2:0] HSIZE, // AHB size, word only
   input wire logic [31:0] HWDATA, // AHB write data
   input wire logic HREADY, // AHB bus ready
   output logic HREADYOUT, // AHB slave ready
   output logic [31:0] HRDATA, // AHB read data
   output logic HRESP, // AHB response, always OKAY
   input wire logic [`SRB_DW-1:0] CASC_IN, // Taps of the previous block
   srb_link_if.user LNK // Link to the RAM block
);

   srb_pkg::srb_usr_st_t s_r;
   srb_pkg::srb_usr_st_t s_nxt;

   function automatic logic [31:0] rd_mux(input srb_pkg::srb_usr_st_t s, input logic [7:0] a);
      case (a)
         `SRB_OFF_CTRL: rd_mux = s.ctrl;
         `SRB_OFF_WADDR: rd_mux = 32'(s.waddr);
         `SRB_OFF_WDATA: rd_mux = 32'(s.wdata);
         `SRB_OFF_RADDR: rd_mux = 32'(s.raddr);
         `SRB_OFF_RDATA: rd_mux = 32'(s.q_cap);
         `SRB_OFF_SHAPE: rd_mux = {16'h0000, 2'h0, s.tap_len, 3'h0, s.shift_w};
         `SRB_OFF_STAT: rd_mux = {31'h00000000, s.bad};
         default: rd_mux = 32'h00000000;
      endcase
   endfunction

   logic take;
   logic shift;
   logic [15:0] need;
   logic [15:0] outs;

   always_comb begin
      take = HSEL && HTRANS[1] && HREADY;
      shift = (s_r.ctrl[`SRB_C_MODE] == 3'(srb_pkg::SRB_SHIFT));
      need = 16'(HWDATA[`SRB_S_W]) * 16'(HWDATA[`SRB_S_LEN]) * 16'(HWDATA[`SRB_S_TAPS]);
      outs = 16'(HWDATA[`SRB_S_W]) * 16'(HWDATA[`SRB_S_TAPS]);
      s_nxt = s_r;
      if (RST) begin
         s_nxt = '0;
         s_nxt.ctrl = `SRB_CTRL_RST;
         s_nxt.tap_len = 6'h01;
         s_nxt.hready = 1'b1;
      end else if (CE) begin
         s_nxt.q_cap = LNK.q;
         s_nxt.wren = shift;
         s_nxt.rden = 1'b0;
         if (take && !HWRITE) begin
            s_nxt.hrdata = rd_mux(s_r, HADDR[7:0]);
         end
         if (s_r.ph_wr) begin
            case (s_r.ph_addr)
               `SRB_OFF_CTRL: s_nxt.ctrl = HWDATA;
               `SRB_OFF_WADDR: s_nxt.waddr = HWDATA[`SRB_AW-1:0];
               `SRB_OFF_WDATA: begin
                  s_nxt.wdata = HWDATA[`SRB_DW-1:0];
                  s_nxt.wren = 1'b1;
               end
               `SRB_OFF_RADDR: begin
                  s_nxt.raddr = HWDATA[`SRB_AW-1:0];
                  s_nxt.rden = 1'b1;
               end
               `SRB_OFF_SHAPE: begin
                  if (need <= 16'(`SRB_CAPACITY) && outs < 16'(`SRB_MAX_PORT) &&
                      HWDATA[`SRB_S_LEN] != 6'h00 && HWDATA[`SRB_S_TAPS] != 4'h0 &&
                      HWDATA[`SRB_S_LEN] <= 6'(`SRB_MAX_TAP)) begin
                     s_nxt.shift_w = HWDATA[`SRB_S_W];
                     s_nxt.tap_len = HWDATA[`SRB_S_LEN];
                     s_nxt.bad = 1'b0;
                  end else begin
                     s_nxt.bad = 1'b1;
                  end
               end
               default: ;
            endcase
         end
         s_nxt.ph_wr = take && HWRITE;
         if (take) begin
            s_nxt.ph_addr = HADDR[7:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      s_r <= s_nxt;
   end

   assign HREADYOUT = s_r.hready;
   assign HRDATA = s_r.hrdata;
   assign HRESP = 1'b0;
   assign LNK.mode = srb_pkg::srb_mode_t'(s_r.ctrl[`SRB_C_MODE]);
   assign LNK.wr_wid = srb_pkg::srb_wid_t'(s_r.ctrl[`SRB_C_WWID]);
   assign LNK.rd_wid = srb_pkg::srb_wid_t'(s_r.ctrl[`SRB_C_RWID]);
   assign LNK.out_reg = s_r.ctrl[`SRB_C_OREG];
   assign LNK.pseudo = s_r.ctrl[`SRB_C_PSEUDO];
   assign LNK.rsel = s_r.ctrl[`SRB_C_RSEL];
   assign LNK.osel = s_r.ctrl[`SRB_C_OSEL];
   assign LNK.bank = s_r.ctrl[`SRB_C_BANK];
   assign LNK.in_ce = s_r.ctrl[`SRB_C_INCE];
   assign LNK.out_ce = s_r.ctrl[`SRB_C_OUTCE];
   assign LNK.in_clr = s_r.ctrl[`SRB_C_INCLR];
   assign LNK.out_clr = s_r.ctrl[`SRB_C_OUTCLR];
   assign LNK.be = s_r.ctrl[`SRB_C_BE];
   assign LNK.wren = s_r.wren;
   assign LNK.rden = s_r.rden;
   assign LNK.wr_addr = s_r.waddr;
   assign LNK.rd_addr = s_r.raddr;
   // Cascade feeds the previous block's taps in shift mode
   assign LNK.wr_data = s_r.ctrl[`SRB_C_CASC] ? CASC_IN : s_r.wdata;
   assign LNK.shift_w = s_r.shift_w;
   assign LNK.tap_len = s_r.tap_len;

endmodule

// ### sim/configurable_embedded_ram_block_test.sv
// Self-checking bench: user logic driving the RAM block over its link
`timescale 1ns/1ps
`include "srb_defs.svh"
module configurable_embedded_ram_block_test;
   localparam srb_pkg::srb_wid_t w18 = srb_pkg::SRB_W18;
   localparam srb_pkg::srb_wid_t w16 = srb_pkg::SRB_W16;
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0;
   logic [`SRB_DW-1:0] CASC_IN = 18'h0;
   logic HREADYOUT;
   logic [31:0] HRDATA;
   logic HRESP;
   logic [31:0] rv;
   int errors = 0;
   int samples_checked = 0;
   srb_link_if lnk ();
   srb_ram i_srb_ram (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .LNK(lnk));
   srb_user i_srb_user (
      .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .CASC_IN(CASC_IN), .LNK(lnk)
   );
   srb_props i_srb_props (
      .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .mode(lnk.mode), .out_reg(lnk.out_reg),
      .pseudo(lnk.pseudo), .in_ce(lnk.in_ce), .out_ce(lnk.out_ce), .in_clr(lnk.in_clr),
      .out_clr(lnk.out_clr), .wren(lnk.wren), .rden(lnk.rden), .shift_w(lnk.shift_w),
      .tap_len(lnk.tap_len), .q(lnk.q)
   );
   initial begin
      forever begin
         #5;
         CLK_SYS = ~CLK_SYS;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One single transfer; read data lands in rv
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 100);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 200);
      if (HREADYOUT !== 1'b1) begin
         check({31'h0, HREADYOUT}, 32'h1);
      end
      rv = HRDATA;
   endtask
   // Byte enables on by default; x toggles further control bits
   task automatic cfg(input srb_pkg::srb_mode_t m, input srb_pkg::srb_wid_t w,
                      input srb_pkg::srb_wid_t r, input logic [31:0] x);
      logic [31:0] v;
      v = (`SRB_CTRL_RST | 32'h00c00000) ^ x;
      v[`SRB_C_MODE] = m;
      v[`SRB_C_WWID] = w;
      v[`SRB_C_RWID] = r;
      bus(1'b1, `SRB_OFF_CTRL, v);
   endtask
   task automatic wr_ram(input logic [8:0] a, input logic [17:0] d);
      bus(1'b1, `SRB_OFF_WADDR, {23'h0, a});
      bus(1'b1, `SRB_OFF_WDATA, {14'h0, d});
   endtask
   // Output settles within three edges; RDATA needs two more
   task automatic rd_ram(input logic [8:0] a, input logic [17:0] exp);
      bus(1'b1, `SRB_OFF_RADDR, {23'h0, a});
      repeat (6) @(posedge CLK_SYS);
      bus(1'b0, `SRB_OFF_RDATA, 32'h0);
      check(rv, {14'h0, exp});
   endtask
   task automatic t_reset;
      bus(1'b0, `SRB_OFF_CTRL, 32'h0);
      check(rv, `SRB_CTRL_RST);
      bus(1'b0, `SRB_OFF_STAT, 32'h0);
      check(rv, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      check(rv, 32'h0);
      check({31'h0, HRESP}, 32'h0);
      cfg(srb_pkg::SRB_SDP, w18, w18, 32'h0);
      rd_ram(9'h5, `SRB_INIT_SEED ^ 18'h5);
      rd_ram(9'h1f, `SRB_INIT_SEED ^ 18'h1f);
      $display("reset test done");
   endtask
   task automatic t_sdp;
      wr_ram(9'h0, 18'h20100);
      wr_ram(9'h1f, 18'h1feff);
      rd_ram(9'h0, 18'h20100);
      rd_ram(9'h1f, 18'h1feff);
      cfg(srb_pkg::SRB_SDP, w18, w18, 32'h00800000);
      wr_ram(9'h9, 18'h3ffff);
      rd_ram(9'h9, ((`SRB_INIT_SEED ^ 18'h9) & 18'h3fe00) | 18'h001ff);
      $display("dual port test done");
   endtask
   task automatic t_mixed;
      srb_pkg::srb_wid_t rw [6] = '{srb_pkg::SRB_W8, srb_pkg::SRB_W8, srb_pkg::SRB_W4,
         srb_pkg::SRB_W2, srb_pkg::SRB_W1, srb_pkg::SRB_W1};
      logic [8:0] ra [6] = '{9'h4, 9'h5, 9'hb, 9'h11, 9'h20, 9'h24};
      logic [17:0] ex [6] = '{18'hef, 18'hbe, 18'hb, 18'h3, 18'h1, 18'h0};
      cfg(srb_pkg::SRB_SDP, w16, w16, 32'h0);
      wr_ram(9'h2, 18'h0beef);
      for (int i = 0; i < 6; i++) begin
         cfg(srb_pkg::SRB_SDP, w16, rw[i], 32'h0);
         rd_ram(ra[i], ex[i]);
      end
      $display("mixed width test done");
   endtask
   task automatic t_oreg;
      cfg(srb_pkg::SRB_SDP, w16, w16, 32'h00001000);
      rd_ram(9'h2, 18'h0beef);
      CE <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      CE <= 1'b1;
      bus(1'b0, `SRB_OFF_RDATA, 32'h0);
      check(rv, 32'h0000beef);
      cfg(srb_pkg::SRB_SDP, w16, w16, 32'h00101000);
      repeat (4) @(posedge CLK_SYS);
      bus(1'b0, `SRB_OFF_RDATA, 32'h0);
      check(rv, 32'h0);
      cfg(srb_pkg::SRB_SDP, w16, w16, 32'h00002000);
      rd_ram(9'h2, 18'h0beef);
      // Output register on the disabled output enable keeps old data
      cfg(srb_pkg::SRB_SDP, w16, w16, 32'h00049000);
      rd_ram(9'h0, 18'h0beef);
      $display("output path test done");
   endtask
   task automatic t_modes;
      cfg(srb_pkg::SRB_SP, w18, w18, 32'h0);
      wr_ram(9'h7, 18'h12345);
      rd_ram(9'h14, 18'h12345);
      cfg(srb_pkg::SRB_SPLIT, w18, w18, 32'h0);
      wr_ram(9'h3, 18'h0aaaa);
      cfg(srb_pkg::SRB_SPLIT, w18, w18, 32'h00010000);
      wr_ram(9'h3, 18'h05555);
      rd_ram(9'h0, 18'h05555);
      cfg(srb_pkg::SRB_SPLIT, w18, w18, 32'h0);
      rd_ram(9'h0, 18'h0aaaa);
      cfg(srb_pkg::SRB_SDP, w18, w18, 32'h0);
      rd_ram(9'h13, 18'h05555);
      cfg(srb_pkg::SRB_ROM, w18, w18, 32'h0);
      wr_ram(9'h4, 18'h3ffff);
      rd_ram(9'h4, `SRB_INIT_SEED ^ 18'h4);
      cfg(srb_pkg::SRB_FIFO, w18, w18, 32'h0);
      wr_ram(9'ha, 18'h1c3a5);
      rd_ram(9'ha, 18'h1c3a5);
      $display("mode test done");
   endtask
   task automatic t_shift;
      bus(1'b1, `SRB_OFF_SHAPE, 32'h00022008);
      bus(1'b0, `SRB_OFF_STAT, 32'h0);
      check(rv, 32'h0);
      bus(1'b1, `SRB_OFF_SHAPE, 32'h00022009);
      bus(1'b0, `SRB_OFF_STAT, 32'h0);
      check(rv, 32'h1);
      bus(1'b1, `SRB_OFF_SHAPE, 32'h00020204);
      bus(1'b1, `SRB_OFF_WDATA, 32'h5);
      cfg(srb_pkg::SRB_SHIFT, w18, w18, 32'h0);
      repeat (20) @(posedge CLK_SYS);
      bus(1'b0, `SRB_OFF_RDATA, 32'h0);
      check(rv & 32'hff, 32'h55);
      CASC_IN <= 18'h0000a;
      cfg(srb_pkg::SRB_SHIFT, w18, w18, 32'h00200000);
      repeat (20) @(posedge CLK_SYS);
      bus(1'b0, `SRB_OFF_RDATA, 32'h0);
      check(rv & 32'hff, 32'haa);
      $display("shift test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      t_reset;
      t_sdp;
      t_mixed;
      t_oreg;
      t_modes;
      t_shift;
      summarize;
   end
   initial begin
      #200000;
      errors++;
      summarize;
   end
endmodule

// ### sim/srb_props.sv
// Link checker for the RAM block and its user logic
`timescale 1ns/1ps
`include "srb_defs.svh"
module srb_props (
   input wire logic CLK_SYS, // System clock
   input wire logic RST, // Synchronous reset
   input wire logic CE, // Global clock enable
   input wire srb_pkg::srb_mode_t mode, // Block mode
   input wire logic out_reg, // Output register used
   input wire logic pseudo, // Pseudo-async read
   input wire logic in_ce, // Input group enable
   input wire logic out_ce, // Output group enable
   input wire logic in_clr, // Input group clear
   input wire logic out_clr, // Output register clear
   input wire logic wren, // Write request
   input wire logic rden, // Read request
   input wire logic [4:0] shift_w, // Tap width
   input wire logic [5:0] tap_len, // Tap length
   input wire logic [`SRB_DW-1:0] q // Read data
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   // Three cycles with no read in flight and nothing that moves the output
   sequence s_quiet;
      (!rden && CE && !in_clr && !out_clr && !pseudo && mode != srb_pkg::SRB_SHIFT
         && $stable(mode) && $stable(out_reg))[*3];
   endsequence
   sequence s_shift_run;
      (mode == srb_pkg::SRB_SHIFT && CE)[*3];
   endsequence
   a_q_holds_idle: assert property (s_quiet |=> $stable(q))
      else $error("read data moved with no read");
   a_ce_freeze_q: assert property (!CE |=> $stable(q))
      else $error("read data moved while disabled");
   a_ce_freeze_ctl: assert property (!CE |=> $stable(wren) && $stable(rden))
      else $error("link strobes moved while disabled");
   a_sp_exclusive: assert property (mode inside {srb_pkg::SRB_SP, srb_pkg::SRB_SPLIT}
      |-> !(wren && rden))
      else $error("read and write together on a single port");
   a_shape_fits: assert property (mode == srb_pkg::SRB_SHIFT
      |-> shift_w * tap_len <= `SRB_CAPACITY && shift_w < `SRB_MAX_PORT)
      else $error("shift shape beyond block size");
   a_shift_wren: assert property (s_shift_run |-> wren)
      else $error("shift mode without a step each cycle");
   a_out_clear: assert property (out_clr && out_reg && CE |=> q == '0)
      else $error("output register not cleared");
   a_reset_state: assert property ($fell(RST) && $past(CE)
      |-> q == '0 && !wren && !rden && in_ce && out_ce && mode == srb_pkg::SRB_SDP)
      else $error("wrong state after reset");
endmodule
